// >>> common/txpll_pkg.sv
// Notes on behaviour
// - one 32-bit configuration word governs everything
// - carrier word plus band select flag
// - integer part 24 or 32.5 by band
// - deviation word added for upper FSK frequency
// - ASK adds half deviation, rounded down
// - modulation select flag picks ASK or FSK
// - FSK steps the feedback divider word only
// - lock declared after 1280 crystal periods
// - amplifier enabled once locked and configured
// - FSK: RF on with amplifier; ASK: pin too
// - FSK: pin high selects upper frequency
// - 4-bit power level sets amplifier current
// - oscillator runs with enable; ready after amplitude
// - clock output divides by four or eight
// - clock output toggles only when enabled
// - clock output low while powered down
// - clock output low until ready and enabled
// - clock activation synchronized, first period full
// - oscillator-only bit powers synthesizer down
// - one pin carries configuration and transmit data
package txpll_pkg;
  // ************************************************************
  // configuration word layout
  // ************************************************************
  localparam int CFG_W = 32;
  localparam int CARRIER_LSB = 0;
  localparam int CARRIER_MSB = 14;
  localparam int BAND_BIT = 15;
  localparam int DEV_LSB = 16;
  localparam int DEV_MSB = 23;
  localparam int PWR_LSB = 24;
  localparam int PWR_MSB = 27;
  localparam int MOD_BIT = 28;
  localparam int DIVSEL_BIT = 29;
  localparam int CLKEN_BIT = 30;
  localparam int OSCONLY_BIT = 31;
  localparam logic [4:0] BIT_LAST = 5'h1F;

  // ************************************************************
  // timing
  // ************************************************************
  // crystal clock is the system clock, so periods equal cycles
  localparam int LOCK_PERIODS = 1280;
  localparam logic [10:0] LOCK_LAST = 11'(LOCK_PERIODS - 1);
  localparam logic [2:0] DIV_IDLE = 3'h7;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam int CTRL_ACCEPT_BIT = 0;
  localparam logic CTRL_ACCEPT_RESET = 1'b1;
  localparam int ST_OSC_READY = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_CFG_DONE = 2;
  localparam int ST_PA_EN = 3;
  localparam int ST_RF_ON = 4;
  localparam int ST_SYNTH_ON = 5;
  localparam int ST_COUNT_LSB = 8;
  localparam int ST_COUNT_MSB = 12;

  typedef enum logic [1:0] {
    LK_OFF = 2'b00,
    LK_SETTLE = 2'b01,
    LK_LOCKED = 2'b10
  } lock_state_t;

  // fractional term of the feedback divider word
  function automatic logic [15:0] frac_word(input logic [14:0] carrier, input logic [7:0] dev,
                                            input logic ask, input logic tx_high);
    logic [7:0] add;
    add = ask ? {1'b0, dev[7:1]} : (tx_high ? dev : 8'h00);
    return {1'b0, carrier} + {8'h00, add};
  endfunction
endpackage

// >>> core/config_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module config_shifter
  import txpll_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // serial side
  input wire logic shift_in,
  input wire logic bit_in,
  input wire logic clear_in,
  // word side
  output logic [CFG_W-1:0] word_out,
  output logic done_out,
  output logic [4:0] count_out
);
  typedef struct packed {
    logic [CFG_W-1:0] sh;
    logic [CFG_W-1:0] word;
    logic [4:0] cnt;
    logic done;
  } shift_state_t;

  shift_state_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (clear_in) begin
      s_nxt.cnt = 5'h00;
    end else if (shift_in) begin
      s_nxt.sh = {s_r.sh[CFG_W-2:0], bit_in};
      if (s_r.cnt == BIT_LAST) begin
        s_nxt.word = {s_r.sh[CFG_W-2:0], bit_in};
        s_nxt.done = 1'b1;
        s_nxt.cnt = 5'h00;
      end else begin
        s_nxt.cnt = 5'(s_r.cnt + 5'h01);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign word_out = s_r.word;
  assign done_out = s_r.done;
  assign count_out = s_r.cnt;

  property p_word_done;
    @(posedge clk_in) disable iff (!rst_n_in)
      shift_in && !clear_in && s_r.cnt == BIT_LAST |=> done_out && word_out[0] == $past(bit_in);
  endproperty
  a_word_done: assert property (p_word_done) else $error("word not completed on last bit");
endmodule
`default_nettype wire

// >>> core/clkout_divider.sv
`timescale 1ns/1ps
`default_nettype none
module clkout_divider
  import txpll_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic run_in,
  input wire logic clk_enable_in,
  input wire logic div4_in,
  // pin
  output logic clk_out
);
  typedef struct packed {
    logic [2:0] cnt;
    logic active;
    logic div4;
    logic out;
  } div_state_t;

  div_state_t s_r, s_nxt;
  logic boundary;

  // enable and ratio change only at a period edge, so no runt pulse
  always_comb begin
    s_nxt = s_r;
    boundary = s_r.div4 ? (s_r.cnt[1:0] == DIV4_LAST) : (s_r.cnt == DIV8_LAST);
    if (!run_in) begin
      s_nxt.cnt = DIV_IDLE;
      s_nxt.active = 1'b0;
      s_nxt.out = 1'b0;
    end else begin
      if (boundary) begin
        s_nxt.cnt = 3'h0;
        s_nxt.active = clk_enable_in;
        s_nxt.div4 = div4_in;
      end else begin
        s_nxt.cnt = 3'(s_r.cnt + 3'h1);
      end
      s_nxt.out = s_nxt.active & ~(s_nxt.div4 ? s_nxt.cnt[1] : s_nxt.cnt[2]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '{cnt: DIV_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign clk_out = s_r.out;

  property p_pd_low;
    @(posedge clk_in) disable iff (!rst_n_in)
      !run_in |=> !clk_out;
  endproperty
  a_pd_low: assert property (p_pd_low) else $error("clock output not low in power-down");

  property p_start_enabled;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(clk_out) |-> $past(run_in && clk_enable_in) || s_r.cnt != 3'h0 || $past(s_r.active);
  endproperty
  a_start_enabled: assert property (p_start_enabled) else $error("clock started while disabled");

  property p_div4_high;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(clk_out) && s_r.div4 && run_in |-> clk_out [*2] ##1 (!clk_out [*2] or !run_in);
  endproperty
  a_div4_high: assert property (p_div4_high) else $error("divide-by-four shape wrong");

  property p_div8_high;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(clk_out) && !s_r.div4 ##1 run_in [*3] |-> clk_out [*1] ##0 $past(clk_out, 3);
  endproperty
  a_div8_high: assert property (p_div8_high) else $error("divide-by-eight high phase short");
endmodule
`default_nettype wire

// >>> core/tx_pll_config_clock_ctrl.sv
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tx_pll_config_clock_ctrl
  import txpll_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // device pins
  input wire logic enable_pin_in,
  input wire logic serial_clk_in,
  input wire logic shared_serial_tx_pin_in,
  input wire logic osc_amp_ok_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // synthesizer and amplifier controls
  output logic osc_ready_flag_out,
  output logic synth_on_out,
  output logic locked_out,
  output logic band_select_out,
  output logic [15:0] fb_frac_out,
  output logic power_amplifier_en_out,
  output logic rf_on_out,
  output logic [3:0] pa_power_level_out,
  // divided crystal clock
  output logic clk_out
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0] en_sync;
    logic [1:0] amp_sync;
    logic [1:0] sck_sync;
    logic [1:0] sdat_sync;
    logic sck_prev;
    logic [CFG_W-1:0] cfg;
    logic cfg_done;
    lock_state_t lock_st;
    logic locked;
    logic [10:0] lock_cnt;
    logic osc_ready;
    logic synth_on;
    logic pa_en;
    logic rf_on;
    logic [15:0] frac;
    logic band;
    logic [3:0] pa_power_level;
    logic ctrl_accept;
    logic wb_ack;
    logic [31:0] wb_dat;
  } top_state_t;

  top_state_t s_r, s_nxt;

  // ************************************************************
  // serial loader
  // ************************************************************
  logic sck_rise;
  logic word_done;
  logic [CFG_W-1:0] word;
  logic [4:0] bit_count;
  logic powered;
  logic tx_level;

  assign powered = s_r.en_sync[1];
  assign sck_rise = s_r.sck_sync[1] & ~s_r.sck_prev;
  assign tx_level = s_r.sdat_sync[1];

  // the same pin bit feeds the shifter and the modulator
  config_shifter u_shifter (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .shift_in(sck_rise & s_r.ctrl_accept),
    .bit_in(tx_level),
    .clear_in(~powered),
    .word_out(word),
    .done_out(word_done),
    .count_out(bit_count)
  );

  // ************************************************************
  // register decode
  // ************************************************************
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] offs);
    return adr == offs;
  endfunction

  logic wb_req;
  logic reload_moves;
  logic [31:0] status_word;

  assign wb_req = wb_cyc_in & wb_stb_in & ~s_r.wb_ack;
  assign reload_moves = word_done &&
    (word[CARRIER_MSB:CARRIER_LSB] != s_r.cfg[CARRIER_MSB:CARRIER_LSB] ||
     word[BAND_BIT] != s_r.cfg[BAND_BIT]);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_OSC_READY] = s_r.osc_ready;
    status_word[ST_LOCKED] = s_r.locked;
    status_word[ST_CFG_DONE] = s_r.cfg_done;
    status_word[ST_PA_EN] = s_r.pa_en;
    status_word[ST_RF_ON] = s_r.rf_on;
    status_word[ST_SYNTH_ON] = s_r.synth_on;
    status_word[ST_COUNT_MSB:ST_COUNT_LSB] = bit_count;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;

    // pin synchronisers
    s_nxt.en_sync = {s_r.en_sync[0], enable_pin_in};
    s_nxt.amp_sync = {s_r.amp_sync[0], osc_amp_ok_in};
    s_nxt.sck_sync = {s_r.sck_sync[0], serial_clk_in};
    s_nxt.sdat_sync = {s_r.sdat_sync[0], shared_serial_tx_pin_in};
    s_nxt.sck_prev = s_r.sck_sync[1];

    // oscillator ready sticks until the enable pin drops
    s_nxt.osc_ready = powered & (s_r.osc_ready | s_r.amp_sync[1]);

    // configuration word
    if (!powered) begin
      s_nxt.cfg_done = 1'b0;
    end else if (word_done) begin
      s_nxt.cfg = word;
      s_nxt.cfg_done = 1'b1;
    end

    // synthesizer runs only in normal operation
    s_nxt.synth_on = powered & s_r.cfg_done & ~s_r.cfg[OSCONLY_BIT];

    // lock timer counts crystal periods from oscillator ready with the synthesizer on
    case (s_r.lock_st)
      LK_OFF: begin
        s_nxt.lock_cnt = 11'h000;
        if (s_r.osc_ready && s_r.synth_on) begin
          s_nxt.lock_st = LK_SETTLE;
        end
      end
      LK_SETTLE: begin
        if (s_r.lock_cnt == LOCK_LAST) begin
          s_nxt.lock_st = LK_LOCKED;
        end else begin
          s_nxt.lock_cnt = 11'(s_r.lock_cnt + 11'h001);
        end
      end
      LK_LOCKED: begin
        s_nxt.lock_cnt = s_r.lock_cnt;
      end
      default: begin
        s_nxt.lock_st = LK_OFF;
      end
    endcase
    if (!s_r.osc_ready || !s_r.synth_on) begin
      s_nxt.lock_st = LK_OFF;
      s_nxt.lock_cnt = 11'h000;
    end else if (reload_moves) begin
      s_nxt.lock_st = LK_SETTLE;
      s_nxt.lock_cnt = 11'h000;
    end
    // own flop so the pin does not hang off a state decode
    s_nxt.locked = s_nxt.lock_st == LK_LOCKED;

    // amplifier waits for lock and a full word
    s_nxt.pa_en = (s_r.lock_st == LK_LOCKED) & s_r.cfg_done & s_r.synth_on;
    // ask keys the carrier with the pin; fsk transmits whenever enabled
    s_nxt.rf_on = s_r.pa_en & (~s_r.cfg[MOD_BIT] | tx_level);

    // divider word: fsk flips between low and high words, oscillator untouched
    s_nxt.frac = frac_word(s_r.cfg[CARRIER_MSB:CARRIER_LSB], s_r.cfg[DEV_MSB:DEV_LSB],
                           s_r.cfg[MOD_BIT], tx_level);
    s_nxt.band = s_r.cfg[BAND_BIT];
    s_nxt.pa_power_level = s_r.cfg[PWR_MSB:PWR_LSB];

    // wishbone: one wait state, unmapped reads give zero
    s_nxt.wb_ack = wb_req;
    s_nxt.wb_dat = 32'h0000_0000;
    if (wb_req) begin
      if (reg_hit(wb_adr_in, REG_CONFIG)) begin
        s_nxt.wb_dat = s_r.cfg;
      end else if (reg_hit(wb_adr_in, REG_STATUS)) begin
        s_nxt.wb_dat = status_word;
      end else if (reg_hit(wb_adr_in, REG_CONTROL)) begin
        s_nxt.wb_dat[CTRL_ACCEPT_BIT] = s_r.ctrl_accept;
        if (wb_we_in && wb_sel_in[0]) begin
          s_nxt.ctrl_accept = wb_dat_in[CTRL_ACCEPT_BIT];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{lock_st: LK_OFF, ctrl_accept: CTRL_ACCEPT_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // clock output
  // ************************************************************
  clkout_divider u_clkout (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .run_in(s_r.osc_ready),
    .clk_enable_in(s_r.cfg[CLKEN_BIT]),
    .div4_in(s_r.cfg[DIVSEL_BIT]),
    .clk_out(clk_out)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  assign wb_dat_out = s_r.wb_dat;
  assign wb_ack_out = s_r.wb_ack;
  assign osc_ready_flag_out = s_r.osc_ready;
  assign synth_on_out = s_r.synth_on;
  assign locked_out = s_r.locked;
  assign band_select_out = s_r.band;
  assign fb_frac_out = s_r.frac;
  assign power_amplifier_en_out = s_r.pa_en;
  assign rf_on_out = s_r.rf_on;
  assign pa_power_level_out = s_r.pa_power_level;

  // ************************************************************
  // checks
  // ************************************************************
  property p_cfg_load;
    @(posedge sys_clk_in) disable iff (!rst_n)
      word_done && powered |=> s_r.cfg_done && s_r.cfg == $past(word);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("word not taken on completion");

  property p_lock_time;
    @(posedge sys_clk_in) disable iff (!rst_n)
      s_r.lock_st == LK_SETTLE && s_r.lock_cnt == 11'h000 && s_r.osc_ready && s_r.synth_on
      ##1 (s_r.lock_st == LK_SETTLE) [*8] |-> s_r.lock_cnt == 11'h008;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock counter not counting periods");

  property p_lock_end;
    @(posedge sys_clk_in) disable iff (!rst_n)
      $rose(s_r.lock_st == LK_LOCKED) |-> $past(s_r.lock_cnt) == LOCK_LAST;
  endproperty
  a_lock_end: assert property (p_lock_end) else $error("locked before 1280 periods");

  property p_pa_gate;
    @(posedge sys_clk_in) disable iff (!rst_n)
      s_r.pa_en |-> $past(s_r.lock_st == LK_LOCKED && s_r.cfg_done && s_r.synth_on);
  endproperty
  a_pa_gate: assert property (p_pa_gate) else $error("amplifier on without lock");

  property p_rf_fsk;
    @(posedge sys_clk_in) disable iff (!rst_n)
      s_r.pa_en && !s_r.cfg[MOD_BIT] |=> s_r.rf_on;
  endproperty
  a_rf_fsk: assert property (p_rf_fsk) else $error("fsk carrier not on");

  property p_rf_ask;
    @(posedge sys_clk_in) disable iff (!rst_n)
      s_r.pa_en && s_r.cfg[MOD_BIT] |=> s_r.rf_on == $past(tx_level);
  endproperty
  a_rf_ask: assert property (p_rf_ask) else $error("ask keying does not follow pin");

  property p_fsk_word;
    @(posedge sys_clk_in) disable iff (!rst_n)
      !s_r.cfg[MOD_BIT] ##1 !s_r.cfg[MOD_BIT] && $stable(s_r.cfg) |->
        s_r.frac == {1'b0, s_r.cfg[CARRIER_MSB:CARRIER_LSB]}
          + ($past(tx_level) ? {8'h00, s_r.cfg[DEV_MSB:DEV_LSB]} : 16'h0000);
  endproperty
  a_fsk_word: assert property (p_fsk_word) else $error("fsk divider word wrong");

  property p_ask_word;
    @(posedge sys_clk_in) disable iff (!rst_n)
      s_r.cfg[MOD_BIT] ##1 $stable(s_r.cfg) |->
        s_r.frac == {1'b0, s_r.cfg[CARRIER_MSB:CARRIER_LSB]}
          + {9'h000, s_r.cfg[DEV_MSB:DEV_LSB+1]};
  endproperty
  a_ask_word: assert property (p_ask_word) else $error("ask divider word wrong");

  property p_osc_ready;
    @(posedge sys_clk_in) disable iff (!rst_n)
      $rose(s_r.osc_ready) |-> $past(s_r.amp_sync[1] && powered);
  endproperty
  a_osc_ready: assert property (p_osc_ready) else $error("ready without amplitude");

  property p_osc_only;
    @(posedge sys_clk_in) disable iff (!rst_n)
      s_r.cfg[OSCONLY_BIT] && $stable(s_r.cfg) |-> !s_r.synth_on ##1 !s_r.pa_en;
  endproperty
  a_osc_only: assert property (p_osc_only) else $error("synthesizer on in oscillator-only");

  property p_reload;
    @(posedge sys_clk_in) disable iff (!rst_n)
      reload_moves && s_r.osc_ready && s_r.synth_on |=>
        s_r.lock_st == LK_SETTLE && s_r.lock_cnt == 11'h000 ##1 !s_r.pa_en;
  endproperty
  a_reload: assert property (p_reload) else $error("lock not restarted on reload");

  property p_wb_ack;
    @(posedge sys_clk_in) disable iff (!rst_n)
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// >>> test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk_in,
  // pins toward the device
  output logic sck_out,
  output logic sdata_out
);
  // ************************************************************
  // serial host
  // ************************************************************
  initial begin
    sck_out = 1'b0;
    sdata_out = 1'b0;
  end

  // fields out of range are pulled back to the nearest legal value
  function automatic logic [31:0] legal(input logic [31:0] w);
    logic [31:0] r;
    r = w;
    if (r[14:0] < 15'h09C4) r[14:0] = 15'h09C4;
    if (r[14:0] > 15'h55F0) r[14:0] = 15'h55F0;
    if (r[23:16] == 8'h00) r[23:16] = 8'h01;
    return r;
  endfunction

  // sck idles low between words; four cycles high and five low keep sync margin
  task automatic send_word(input logic [31:0] w);
    logic [31:0] v;
    v = legal(w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_in) sdata_out <= v[i];
      repeat (4) @(posedge clk_in);
      sck_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sck_out <= 1'b0;
    end
  endtask

  // same pin carries transmit data outside words
  task automatic tx_level(input logic v);
    @(posedge clk_in) sdata_out <= v;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_tx_pll_config_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tx_pll_config_clock_ctrl
  import txpll_pkg::*;
;
  logic sys_clk, rst_n, en_pin, amp_ok, cyc, stb, we, ack, sck, sdata;
  logic osc_rdy, synth_on, locked, band, pa_en, rf_on, clk_o;
  logic lk_prev = 1'b0;
  logic lk_drop = 1'b0;
  logic [7:0] adr;
  logic [3:0] sel, pa_power_level;
  logic [31:0] wdat, rdat, q, w;
  logic [15:0] frac;
  logic [5:0] st;
  int errors = 0;
  int comparisons = 0;
  int seed = 32'h4D1A;
  int n, h;
  int lk_cnt = 0;
  int lk_last = 0;

  assign st = {clk_o, rf_on, pa_en, locked, synth_on, osc_rdy};

  tx_pll_config_clock_ctrl dut_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .enable_pin_in(en_pin), .serial_clk_in(sck), .shared_serial_tx_pin_in(sdata),
    .osc_amp_ok_in(amp_ok), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .osc_ready_flag_out(osc_rdy), .synth_on_out(synth_on),
    .locked_out(locked), .band_select_out(band), .fb_frac_out(frac),
    .power_amplifier_en_out(pa_en), .rf_on_out(rf_on), .pa_power_level_out(pa_power_level),
    .clk_out(clk_o));

  host_model host_u (.clk_in(sys_clk), .sck_out(sck), .sdata_out(sdata));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  // settle time from synthesizer on or lock loss to the locked edge
  always @(posedge sys_clk) begin
    lk_prev <= locked;
    if (lk_prev && !locked) lk_drop <= 1'b1;
    if (!synth_on || locked) lk_cnt <= 0;
    else lk_cnt <= lk_cnt + 1;
    if (locked && !lk_prev) lk_last <= lk_cnt;
  end

  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_on(input int i, input logic v);
    n = 0;
    while (st[i] !== v && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // a high phase already under way would read short
  task automatic hi_len();
    wait_on(5, 1'b0);
    wait_on(5, 1'b1);
    h = 0;
    while (clk_o === 1'b1 && h < 20) begin
      @(posedge sys_clk);
      h++;
    end
  endtask

  task automatic load(input logic [31:0] v);
    host_u.send_word(v);
    repeat (8) @(posedge sys_clk);
    wb(1'b0, REG_CONFIG, 32'h0);
  endtask

  // m packs osc-only, clock enable, divide-by-four, ask
  function automatic logic [31:0] mk(input logic [3:0] m);
    logic [14:0] c;
    logic [7:0] d;
    c = 15'(2500 + ($unsigned($random(seed)) % 19501));
    d = 8'(1 + ($unsigned($random(seed)) % 255));
    return {m, 4'($random(seed)), d, 1'($random(seed)), c};
  endfunction

  function automatic logic [15:0] exp_frac(input logic [31:0] v, input logic tx);
    if (v[28]) return {1'b0, v[14:0]} + 16'(v[23:17]);
    return {1'b0, v[14:0]} + 16'(tx ? v[23:16] : 8'h00);
  endfunction

  function automatic logic [31:0] lock_ok();
    return {31'h0, lk_last >= 1278 && lk_last <= 1282};
  endfunction

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    {rst_n, en_pin, amp_ok, cyc, stb, we} = 6'h00;
    {adr, wdat} = '0;
    sel = 4'hF;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wb(1'b0, REG_CONTROL, 32'h0);
    chk(q[0], 1);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 0);
    wb(1'b1, REG_CONFIG, 32'hFFFFFFFF);
    load(32'hC0001234);
    chk(q, 0);
    chk(clk_o, 0);
    en_pin <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(osc_rdy, 0);
    amp_ok <= 1'b1;
    wait_on(0, 1'b1);
    chk(osc_rdy, 1);
    w = mk(4'h6);
    load(w);
    chk(q, w);
    chk(band, w[15]);
    chk(pa_power_level, w[27:24]);
    hi_len();
    chk(h, 2);
    wait_on(2, 1'b1);
    chk(pa_en, 0);
    wait_on(4, 1'b1);
    chk(pa_en, 1);
    chk(rf_on, 1);
    chk(lock_ok(), 1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h0000_003F);
    host_u.tx_level(1'b0);
    repeat (6) @(posedge sys_clk);
    chk(frac, exp_frac(w, 1'b0));
    w = {4'h5, w[27:24], w[23:17], 1'b1, w[15:0]};
    load(w);
    // pin still holds the last word bit, which may be high
    host_u.tx_level(1'b0);
    repeat (6) @(posedge sys_clk);
    chk(lk_drop, 0);
    chk(rf_on, 0);
    chk(frac, exp_frac(w, 1'b0));
    host_u.tx_level(1'b1);
    repeat (6) @(posedge sys_clk);
    chk(rf_on, 1);
    hi_len();
    chk(h, 4);
    w = {8'h0F, 8'hFF, ~w[15], 15'h55F0};
    load(w);
    chk(locked, 0);
    chk(pa_en, 0);
    h = 0;
    repeat (32) @(posedge sys_clk) h += int'(clk_o);
    chk(h, 0);
    wait_on(2, 1'b1);
    @(posedge sys_clk);
    chk(lock_ok(), 1);
    for (int i = 0; i < 6; i++) begin
      host_u.tx_level(1'($random(seed)));
      repeat (5) @(posedge sys_clk);
      chk(frac, exp_frac(w, sdata));
    end
    wb(1'b1, REG_CONTROL, 32'h0);
    load(mk(4'h6));
    chk(q, w);
    wb(1'b1, REG_CONTROL, 32'h1);
    load(mk(4'hE));
    repeat (4) @(posedge sys_clk);
    chk(synth_on, 0);
    hi_len();
    chk(h, 2);
    en_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(clk_o, 0);
    chk(osc_rdy, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
